/* logic/exp_bus_pkg.sv */
// Shared constants and carriers for the expansion bus access sequencer
// What this block does
// - The address phase lasts its parameter plus one clock, with the parameter held to at least 2.
// - The setup phase lasts its parameter plus one clock, with the parameter held to at least 2.
// - The strobe phase lasts its parameter plus one clock, with the parameter held to at least 1.
// - The address and strobe phases never advance while the peripheral reports not ready.
// - After not ready clears, the current phase is held for at least one more clock.
// - Not ready may rise at any clock, so it is sampled every cycle of an access.
// - A recovery phase of 2 to 17 cycles separates successive accesses.
// - Without wait, the data strobe pulse should last 4 to 5 bus clocks; here it lasts its parameter plus one, 2 to 16 clocks.
// - On a simplex write, write data stays driven for a fixed 4 cycles after the strobe rises.
// - Every phase length and count is in periods of the bus clock.
// - The address is driven in the same cycle as the chip select is asserted.
// - One shared active-low wait input serves chip selects 0 to 7 in both strobe styles.
// - Synchronous writes in the separate-strobe style ignore the wait input.
// - If wait clears before the programmed strobe length, the strobe phase ends early.
package exp_bus_pkg;
	localparam int unsigned ADDR_W         = 24;
	localparam int unsigned DATA_W         = 16;
	localparam int unsigned CS_NUM         = 8;
	localparam int unsigned PARAM_W        = 4;
	localparam int unsigned REC_W          = 5;
	localparam int unsigned CNT_W          = 6;
	localparam logic [PARAM_W-1:0] ADDR_PARAM_MIN  = 4'h2;
	localparam logic [PARAM_W-1:0] SETUP_PARAM_MIN = 4'h2;
	localparam logic [PARAM_W-1:0] STRB_PARAM_MIN  = 4'h1;
	localparam logic [REC_W-1:0]   REC_MIN         = 5'h02;
	localparam logic [REC_W-1:0]   REC_MAX         = 5'h11;
	localparam logic [CNT_W-1:0]   HOLD_CYC        = 6'h04;

	typedef enum logic
	{
		STYLE_SEPARATE,
		STYLE_COMBINED
	} strobe_style_t;

	typedef struct packed
	{
		logic [ADDR_W-1:0]      addr;
		logic [DATA_W-1:0]      wdata;
		logic                   write;
		logic                   sync;
		strobe_style_t          style;
		logic [2:0]             cs;
	} access_req_t;

	typedef struct packed
	{
		logic [PARAM_W-1:0] address_phase_param;
		logic [PARAM_W-1:0] setup_phase_param;
		logic [PARAM_W-1:0] strobe_phase_param;
		logic [REC_W-1:0]   recovery_phase_param;
	} phase_cfg_t;
endpackage

/* logic/exp_bus_seq.sv */
// Expansion bus access sequencer with not-ready and wait handshakes
`timescale 1ns/1ps
module exp_bus_seq
(
	input  wire logic                              clk,
	input  wire logic                              rst_b,
	input  wire logic                              req_valid,
	output logic                                   req_ready,
	input  wire exp_bus_pkg::access_req_t          req,
	input  wire exp_bus_pkg::phase_cfg_t           cfg,
	output logic                                   rd_valid,
	output logic [exp_bus_pkg::DATA_W-1:0]         rd_data,
	output logic [exp_bus_pkg::CS_NUM-1:0]         chip_select_low,
	output logic [exp_bus_pkg::ADDR_W-1:0]         bus_addr,
	output logic                                   host_data_strobe_low,
	output logic                                   bus_write,
	output logic [exp_bus_pkg::DATA_W-1:0]         bus_data_out,
	output logic                                   bus_data_oe,
	input  wire logic [exp_bus_pkg::DATA_W-1:0]    bus_data_in,
	input  wire logic                              host_not_ready,
	input  wire logic                              io_wait_low
);
	typedef enum logic [2:0]
	{
		ST_IDLE,
		ST_ADDR,
		ST_SETUP,
		ST_STROBE,
		ST_HOLD,
		ST_RECOV
	} phase_t;

	phase_t                               state_q;
	phase_t                               state_d;
	exp_bus_pkg::access_req_t             req_q;
	logic [exp_bus_pkg::CNT_W-1:0]        cnt_q;
	logic [1:0]                           nr_sync_q;
	logic [1:0]                           wt_sync_q;
	logic [exp_bus_pkg::DATA_W-1:0]       din_s0_q;
	logic [exp_bus_pkg::DATA_W-1:0]       din_s1_q;
	logic                                 nr_prev_q;
	logic                                 waited_q;
	logic                                 rd_valid_q;
	logic [exp_bus_pkg::DATA_W-1:0]       rd_data_q;
	logic                                 not_ready;
	logic                                 wait_used;
	logic                                 wait_now;
	logic                                 nr_clear;
	logic [exp_bus_pkg::CNT_W-1:0]        addr_p;
	logic [exp_bus_pkg::CNT_W-1:0]        setup_p;
	logic [exp_bus_pkg::CNT_W-1:0]        strb_p;
	logic [exp_bus_pkg::CNT_W-1:0]        rec_p;
	logic                                 strobe_end;

	// Raise a phase parameter to its floor, widened to the counter
	function automatic logic [exp_bus_pkg::CNT_W-1:0] floor_param
	(
		input logic [exp_bus_pkg::PARAM_W-1:0] v,
		input logic [exp_bus_pkg::PARAM_W-1:0] lo
	);
		logic [exp_bus_pkg::PARAM_W-1:0] r;
		r = (v < lo) ? lo : v;
		return {2'h0, r};
	endfunction

	// Counts end at param, so each phase spans param plus one clocks
	assign addr_p  = floor_param(cfg.address_phase_param, exp_bus_pkg::ADDR_PARAM_MIN);
	assign setup_p = floor_param(cfg.setup_phase_param, exp_bus_pkg::SETUP_PARAM_MIN);
	assign strb_p  = floor_param(cfg.strobe_phase_param, exp_bus_pkg::STRB_PARAM_MIN);

	// Recovery held to its documented window; counter ends at length minus one
	always_comb
	begin
		logic [exp_bus_pkg::REC_W-1:0] r;
		r = cfg.recovery_phase_param;
		if (r < exp_bus_pkg::REC_MIN)
			r = exp_bus_pkg::REC_MIN;
		else if (r > exp_bus_pkg::REC_MAX)
			r = exp_bus_pkg::REC_MAX;
		rec_p = {1'h0, r} - 6'h01;
	end

	// Two-flop synchronisers; only the second stage feeds logic
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			nr_sync_q   <= 2'h0;
			wt_sync_q   <= 2'h3;
			din_s0_q    <= 16'h0000;
			din_s1_q    <= 16'h0000;
		end
		else
		begin
			nr_sync_q   <= {nr_sync_q[0], host_not_ready};
			wt_sync_q   <= {wt_sync_q[0], io_wait_low};
			din_s0_q    <= bus_data_in;
			din_s1_q    <= din_s0_q;
		end
	end

	assign not_ready = nr_sync_q[1];
	// Wait only counts while a strobe runs; idle level is the board's job
	assign wait_used = !(req_q.style == exp_bus_pkg::STYLE_SEPARATE && req_q.sync && req_q.write);
	assign wait_now  = wait_used && !wt_sync_q[1];
	// One extra clock after not ready clears, hence the delayed copy
	assign nr_clear  = !not_ready && !nr_prev_q;

	// Early end once wait has come and gone; otherwise programmed length, stretched by wait
	assign strobe_end = nr_clear && !wait_now && (waited_q || cnt_q >= strb_p);

	// Phase sequencing
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:
				if (req_valid)
					state_d = ST_ADDR;
			ST_ADDR:
				if (cnt_q >= addr_p && nr_clear)
					state_d = ST_SETUP;
			ST_SETUP:
				if (cnt_q >= setup_p)
					state_d = ST_STROBE;
			ST_STROBE:
				if (strobe_end)
					state_d = req_q.write ? ST_HOLD : ST_RECOV;
			ST_HOLD:
				if (cnt_q >= exp_bus_pkg::HOLD_CYC - 6'h01)
					state_d = ST_RECOV;
			ST_RECOV:
				if (cnt_q >= rec_p)
					state_d = ST_IDLE;
			default:
				state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	// Phase cycle counter, cleared on every phase change
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			cnt_q <= 6'h00;
		else if (state_d != state_q)
			cnt_q <= 6'h00;
		else if (cnt_q != 6'h3f)
			cnt_q <= cnt_q + 6'h01;
	end

	// Not-ready history, sampled on every cycle of an access
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			nr_prev_q <= 1'b0;
		else
			nr_prev_q <= not_ready;
	end

	// Remembers that wait was seen in the current strobe
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			waited_q <= 1'b0;
		else if (state_q != ST_STROBE)
			waited_q <= 1'b0;
		else if (wait_now)
			waited_q <= 1'b1;
	end

	// Request capture; held stable for the whole access
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			req_q <= '0;
		else if (state_q == ST_IDLE && req_valid)
			req_q <= req;
	end

	// Read data taken from the synchronised bus at strobe end
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rd_valid_q <= 1'b0;
			rd_data_q  <= 16'h0000;
		end
		else
		begin
			rd_valid_q <= state_q == ST_STROBE && strobe_end && !req_q.write;
			if (state_q == ST_STROBE && strobe_end && !req_q.write)
				rd_data_q <= din_s1_q;
		end
	end

	assign req_ready = state_q == ST_IDLE;
	assign rd_valid  = rd_valid_q;
	assign rd_data   = rd_data_q;

	// Pin decode from registered state; address and select share one flop set
	always_comb
	begin
		chip_select_low = 8'hff;
		if (state_q != ST_IDLE && state_q != ST_RECOV)
			chip_select_low[req_q.cs] = 1'b0;
	end

	assign bus_addr             = (state_q == ST_IDLE) ? 24'h000000 : req_q.addr;
	assign host_data_strobe_low = state_q != ST_STROBE;
	assign bus_write            = req_q.write && state_q != ST_IDLE;
	assign bus_data_out         = req_q.wdata;
	// Write data kept on the pins through the hold phase after the strobe rises
	assign bus_data_oe          = req_q.write && (state_q == ST_SETUP || state_q == ST_STROBE
	                              || state_q == ST_HOLD);

	a_addr_len: assert property (@(posedge clk) disable iff (!rst_b)
		(state_q == ST_ADDR && state_d == ST_SETUP) |-> cnt_q >= addr_p && cnt_q >= 6'h02)
		else $error("address phase too short");

	a_setup_len: assert property (@(posedge clk) disable iff (!rst_b)
		(state_q == ST_SETUP && state_d != ST_SETUP) |-> cnt_q == setup_p)
		else $error("setup phase length wrong");

	a_strobe_len: assert property (@(posedge clk) disable iff (!rst_b)
		(state_q == ST_STROBE && state_d != ST_STROBE && !waited_q) |-> cnt_q >= strb_p)
		else $error("strobe phase ended early without wait");

	a_nr_holds: assert property (@(posedge clk) disable iff (!rst_b)
		((state_q == ST_ADDR || state_q == ST_STROBE) && not_ready) |=> state_q == $past(state_q))
		else $error("phase left while not ready");

	a_nr_extra: assert property (@(posedge clk) disable iff (!rst_b)
		((state_q == ST_ADDR || state_q == ST_STROBE) && $fell(not_ready)) |=> $stable(state_q))
		else $error("no extra clock after not ready cleared");

	a_recov_len: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(state_q == ST_RECOV) |-> (state_q == ST_RECOV)[*2])
		else $error("recovery shorter than two cycles");

	a_cs_addr: assert property (@(posedge clk) disable iff (!rst_b)
		(chip_select_low != 8'hff) |-> bus_addr == req_q.addr && !chip_select_low[req_q.cs])
		else $error("address not driven with chip select");

	a_wait_ignored: assert property (@(posedge clk) disable iff (!rst_b)
		(state_q == ST_STROBE && !wait_used && cnt_q >= strb_p && nr_clear) |=> state_q != ST_STROBE)
		else $error("wait not ignored on synchronous write");

	a_wait_extend: assert property (@(posedge clk) disable iff (!rst_b)
		(state_q == ST_STROBE && wait_now) |=> state_q == ST_STROBE)
		else $error("strobe ended while wait asserted");

	a_write_hold: assert property (@(posedge clk) disable iff (!rst_b)
		(state_q == ST_STROBE && state_d == ST_HOLD) |=> bus_data_oe[*4])
		else $error("write data hold too short");
endmodule

/* tb/exp_bus_peer.sv */
// Far-side peripheral model: not ready, wait line and read data
`timescale 1ns/1ps
module exp_bus_peer
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic [7:0]  chip_select_low,
	input  wire logic        host_data_strobe_low,
	input  wire logic [23:0] bus_addr,
	input  wire logic [1:0]  nr_mode,
	input  wire logic [7:0]  nr_len,
	input  wire logic [7:0]  wait_len,
	output logic [15:0]      bus_data_in,
	output logic             host_not_ready,
	output logic             io_wait_low
);
	logic [7:0]  cs_cnt_q;
	logic [7:0]  st_cnt_q;
	logic        drv_q;
	logic [15:0] pat;
	// Cycles selected and strobed, the base of every commanded stall
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cs_cnt_q <= 8'h00;
			st_cnt_q <= 8'h00;
			drv_q    <= 1'b0;
		end
		else
		begin
			cs_cnt_q <= (&chip_select_low) ? 8'h00 : cs_cnt_q + 8'h01;
			st_cnt_q <= host_data_strobe_low ? 8'h00 : st_cnt_q + 8'h01;
			drv_q    <= !(&chip_select_low) && (drv_q || !host_data_strobe_low);
		end
	end
	// Not ready may rise in either stalling phase, as the bench commands
	assign host_not_ready = (nr_mode == 2'h1 && !(&chip_select_low) && cs_cnt_q < nr_len)
		|| (nr_mode == 2'h2 && !host_data_strobe_low && st_cnt_q < nr_len);
	// Wait pulled low only inside the strobe; idle leaves it high
	assign io_wait_low = !(!host_data_strobe_low && st_cnt_q < wait_len);
	// Released bus shows the inverse, so a stale sample never matches
	assign pat = bus_addr[15:0] ^ 16'h5a5a;
	assign bus_data_in = (drv_q || !host_data_strobe_low) ? pat : ~pat;
endmodule

/* tb/exp_bus_seq_tb_top.sv */
// Self-checking bench for the expansion bus access sequencer
`timescale 1ns/1ps
module exp_bus_seq_tb_top;
	typedef struct {logic [3:0] a, s, t; logic [4:0] r; logic wr; int lead, strb, hold, rec;} row_t;
	logic                       clk, rst_b, req_valid, req_ready, rd_valid, bus_write;
	logic                       host_data_strobe_low, bus_data_oe, host_not_ready, io_wait_low;
	exp_bus_pkg::access_req_t   req;
	exp_bus_pkg::phase_cfg_t    cfg;
	logic [15:0]                rd_data, bus_data_out, bus_data_in;
	logic [7:0]                 chip_select_low, nr_len, wait_len;
	logic [23:0]                bus_addr;
	logic [1:0]                 nr_mode;
	int                         error_cnt, compares, lead, strb, hold, rec, rdok;
	// Phase params, direction, then expected lead, strobe, hold, recovery
	row_t rows [5] = '{'{4'h2, 4'h2, 4'h3, 5'h02, 1'b1, 6, 4, 4, 2},
		'{4'h2, 4'h2, 4'h4, 5'h11, 1'b0, 6, 5, 0, 17}, '{4'h0, 4'h0, 4'h0, 5'h00, 1'b1, 6, 2, 4, 2},
		'{4'h5, 4'h3, 4'h1, 5'h1f, 1'b1, 10, 2, 4, 17}, '{4'hf, 4'hf, 4'hf, 5'h05, 1'b0, 32, 16, 0, 5}};
	exp_bus_seq dut (.clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req_ready(req_ready),
		.req(req), .cfg(cfg), .rd_valid(rd_valid), .rd_data(rd_data),
		.chip_select_low(chip_select_low), .bus_addr(bus_addr),
		.host_data_strobe_low(host_data_strobe_low), .bus_write(bus_write),
		.bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe), .bus_data_in(bus_data_in),
		.host_not_ready(host_not_ready), .io_wait_low(io_wait_low));
	exp_bus_peer peer (.clk(clk), .rst_b(rst_b), .chip_select_low(chip_select_low),
		.host_data_strobe_low(host_data_strobe_low), .bus_addr(bus_addr), .nr_mode(nr_mode),
		.nr_len(nr_len), .wait_len(wait_len), .bus_data_in(bus_data_in),
		.host_not_ready(host_not_ready), .io_wait_low(io_wait_low));
	always #4 clk = ~clk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("mismatches %0d of %0d compares", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// One access, counting each phase as seen at the pins
	task automatic access(input exp_bus_pkg::phase_cfg_t c, input logic wr, input logic sy,
		input exp_bus_pkg::strobe_style_t st, input logic [2:0] cs, input logic [23:0] ad,
		input logic [1:0] nm, input logic [7:0] nl, input logic [7:0] wl);
		int n;
		@(posedge clk);
		cfg <= c;
		nr_mode <= nm;
		nr_len <= nl;
		wait_len <= wl;
		req <= '{ad, ad[15:0] ^ 16'hc3a0, wr, sy, st, cs};
		req_valid <= 1'b1;
		@(posedge clk);
		req_valid <= 1'b0;
		{lead, strb, hold, rec, rdok, n} = '0;
		// Sample settled pins just after each edge, never in the edge's own step
		#1;
		while (n < 300 && !(req_ready === 1'b1))
		begin
			if (rd_valid === 1'b1)
			begin
				rdok++;
				chk(rd_data, ad[15:0] ^ 16'h5a5a);
			end
			if (host_data_strobe_low === 1'b0)
			begin
				chk({bus_data_oe, bus_write}, {wr, wr});
				strb++;
			end
			else if (chip_select_low !== 8'hff && strb == 0)
			begin
				if (lead == 0)
				begin
					chk({chip_select_low, bus_addr}, {~(8'h01 << cs), ad});
					chk(bus_write, wr);
				end
				lead++;
			end
			else if (chip_select_low !== 8'hff)
			begin
				hold++;
				chk({bus_data_oe, bus_data_out}, {1'b1, ad[15:0] ^ 16'hc3a0});
			end
			else if (req_ready === 1'b0)
				rec++;
			n++;
			@(posedge clk);
			#1;
		end
		// An access that never returns to idle counts as a mismatch
		chk(req_ready, 1'b1);
	endtask
	initial
	begin
		{clk, rst_b, req_valid, req, cfg, nr_mode, nr_len, wait_len} = '0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		foreach (rows[i])
		begin
			access('{rows[i].a, rows[i].s, rows[i].t, rows[i].r}, rows[i].wr, 1'b0,
				exp_bus_pkg::STYLE_SEPARATE, 3'(i), 24'h012340 + 24'(i), 2'h0, 8'h00, 8'h00);
			chk(lead, rows[i].lead);
			chk(strb, rows[i].strb);
			chk(hold, rows[i].hold);
			chk(rec, rows[i].rec);
			chk(rdok, {31'h0, !rows[i].wr});
		end
		// Stalls, stretched and shortened strobes, and an ignored wait
		access('{4'h2, 4'h2, 4'h3, 5'h02}, 1'b0, 1'b0, exp_bus_pkg::STYLE_SEPARATE, 3'h7,
			24'hfedcba, 2'h1, 8'h06, 8'h00);
		chk(lead >= 12, 1);
		access('{4'h2, 4'h2, 4'h3, 5'h02}, 1'b1, 1'b0, exp_bus_pkg::STYLE_SEPARATE, 3'h6,
			24'h00beef, 2'h2, 8'h04, 8'h00);
		chk(strb >= 7, 1);
		access('{4'h2, 4'h2, 4'h3, 5'h02}, 1'b0, 1'b0, exp_bus_pkg::STYLE_COMBINED, 3'h7,
			24'h0a0b0c, 2'h0, 8'h00, 8'h08);
		chk(strb >= 10, 1);
		access('{4'h2, 4'h2, 4'h6, 5'h02}, 1'b0, 1'b0, exp_bus_pkg::STYLE_SEPARATE, 3'h5,
			24'h001234, 2'h0, 8'h00, 8'h01);
		chk(strb < 7, 1);
		access('{4'h2, 4'h2, 4'h3, 5'h02}, 1'b1, 1'b1, exp_bus_pkg::STYLE_SEPARATE, 3'h3,
			24'h004321, 2'h0, 8'h00, 8'h08);
		chk(strb, 4);
		// Reset in mid-access, before the strobe, drops the select at once and leaves the strobe high
		@(posedge clk);
		req_valid <= 1'b1;
		@(posedge clk);
		req_valid <= 1'b0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b0;
		#2;
		chk({chip_select_low, bus_addr}, {8'hff, 24'h0});
		chk({host_data_strobe_low, bus_data_oe, req_ready, rd_valid}, 4'ha);
		@(posedge clk);
		rst_b <= 1'b1;
		access(cfg, 1'b1, 1'b0, exp_bus_pkg::STYLE_SEPARATE, 3'h1, 24'h000100, 2'h0, 8'h00, 8'h00);
		chk(lead, 6);
		tally_and_finish();
	end
	// Longest path is well under this limit, 200000 ns or 25000 clock cycles
	initial
	begin
		#200000;
		error_cnt++;
		tally_and_finish();
	end
endmodule
